// [acs_params.svh]
// Purpose: Constants for the ADC channel sequencer control block
// Assumes: One 40 MHz clock, classic Wishbone slave, 32-bit data
// Notes: Register offsets are byte addresses
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH
`define ACS_OFS_CTRL 8'h00
`define ACS_OFS_STAT 8'h04
`define ACS_OFS_RSLT 8'h08
`define ACS_F_RANGE 0
`define ACS_F_SEQ_B0 1
`define ACS_F_SEQ_B1 2
`define ACS_F_TYP_B0 3
`define ACS_F_TYP_B1 4
`define ACS_F_CH_B0 5
`define ACS_F_CH_B1 6
`define ACS_F_REF 8
`define ACS_F_CODING 9
`define ACS_F_PWR_B0 10
`define ACS_F_PWR_B1 11
`define ACS_CTRL_W 12
`define ACS_CTRL_RST 12'h000
`define ACS_CONV_PERIODS 13
`define ACS_CLK_DIV 4
`define ACS_RES_BITS 12
`endif

// [acs_pkg.sv]
// Purpose: Shared types of the converter control block
// Assumes: State enum codes are left to the tool; power mode codes count 0 to 3 in order
// Notes: Power mode order follows the two power select bits
package acs_pkg;
    typedef enum {ACS_IDLE, ACS_CONV, ACS_DONE} acs_state_t;
    typedef enum logic [1:0] {
        ACS_PM_NORMAL, ACS_PM_AUTO_SHUT, ACS_PM_AUTO_STBY, ACS_PM_FULL_SHUT
    } acs_pm_t;
endpackage

// [acs_sar_if.sv]
// Purpose: Link between control logic and approximation engine
// Assumes: Both sides run on the one system clock
// Notes: Comparator level passes straight through
`timescale 1ns/10ps
interface acs_sar_if;
    logic start;
    logic tick;
    logic abort;
    logic comp_hi;
    logic done;
    logic [11:0] code;
    modport ctrl (output start, output tick, output abort, input done,
        input code);
    modport sar (input start, input tick, input abort, input comp_hi,
        output done, output code);
endinterface

// [acs_sar.sv]
// Purpose: Successive approximation engine of the converter
// Assumes: One trial bit per conversion clock tick
// Notes: Trial count is the resolution; rest of 13 ticks is sampling
`timescale 1ns/10ps
`include "acs_params.svh"
module acs_sar
    import acs_pkg::*;
#(
    parameter int RES_BITS = `ACS_RES_BITS
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    acs_sar_if.sar sif
);
    logic [11:0] trial_q;
    logic [11:0] bit_q;
    logic busy_q;
    logic done_q;
    wire logic [11:0] kept = sif.comp_hi ? trial_q : (trial_q & ~bit_q);
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            trial_q <= 12'h000;
            bit_q <= 12'h000;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else if (sif.start || sif.abort) begin
            bit_q <= 12'(1 << (RES_BITS - 1));
            trial_q <= 12'(1 << (RES_BITS - 1));
            busy_q <= sif.start;
            done_q <= 1'b0;
        end else if (busy_q && sif.tick) begin
            // Rebalance ends when the last trial bit is judged
            trial_q <= (bit_q == 12'h001) ? kept : (kept | (bit_q >> 1));
            bit_q <= bit_q >> 1;
            busy_q <= (bit_q != 12'h001);
            done_q <= (bit_q == 12'h001);
        end
    end
    assign sif.done = done_q;
    assign sif.code = trial_q;
endmodule // acs_sar

// [acs_ctrl.sv]
// Purpose: ADC control word, input decode, sequencer, conversion timing
// Assumes: Classic Wishbone slave, one-cycle ack, conversion clock enable
// Notes: Mixed sequence codes and input type 11 are host errors
`timescale 1ns/10ps
`include "acs_params.svh"
module acs_ctrl
    import acs_pkg::*;
#(
    parameter int RES_BITS = `ACS_RES_BITS,
    parameter int CLK_DIV = `ACS_CLK_DIV
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic convert_start_strobe,
    input wire logic conversion_clock,
    input wire logic comp_hi,
    output logic [3:0] vin_pos_sel,
    output logic [3:0] vin_neg_sel,
    output logic neg_to_analog_ground,
    output logic ref_powered,
    output logic core_powered,
    output logic result_valid
);
    acs_sar_if sif();
    acs_sar #(.RES_BITS(RES_BITS)) u_sar (
        .ref_clk(ref_clk), .rst_n(rst_n), .sif(sif));
    assign sif.comp_hi = comp_hi;

    logic [`ACS_CTRL_W-1:0] ctrl_q;
    logic [1:0] ptr_q;
    logic [1:0] conv_ch_q;
    logic strobe_q;
    logic clk_q;
    logic [3:0] tick_cnt_q;
    logic asleep_q;
    logic [11:0] result_q;
    logic valid_q;
    logic aborted_q;
    logic ack_q;
    acs_state_t st_q;

    // Host may rewrite control any time, including during shutdown
    wire logic wb_req = wb_cyc_i && wb_stb_i && !ack_q;
    wire logic ctrl_wr = wb_req && wb_we_i &&
        (wb_adr_i == `ACS_OFS_CTRL) && (wb_sel_i[1:0] == 2'b11);
    wire logic [`ACS_CTRL_W-1:0] ctrl_new = wb_dat_i[`ACS_CTRL_W-1:0];
    wire logic seq_on = ctrl_q[`ACS_F_SEQ_B1] && ctrl_q[`ACS_F_SEQ_B0];
    wire logic new_seq_on = ctrl_new[`ACS_F_SEQ_B1] && ctrl_new[`ACS_F_SEQ_B0];
    wire logic diff_mode = ctrl_q[`ACS_F_TYP_B1] ^ ctrl_q[`ACS_F_TYP_B0];
    wire logic [1:0] addr = {ctrl_q[`ACS_F_CH_B1], ctrl_q[`ACS_F_CH_B0]};
    wire acs_pm_t pm =
        acs_pm_t'({ctrl_q[`ACS_F_PWR_B1], ctrl_q[`ACS_F_PWR_B0]});
    wire logic strobe_rise = convert_start_strobe && !strobe_q;
    wire logic strobe_fall = !convert_start_strobe && strobe_q;
    wire logic clk_fall = !conversion_clock && clk_q;
    wire logic tick = clk_fall;

    // Next channel of a sequence; pairs step by two
    function automatic logic [1:0] next_ch(input logic [1:0] cur,
        input logic [1:0] last, input logic diff);
        logic [1:0] step;
        step = diff ? 2'd2 : 2'd1;
        if ((diff ? {cur[1], 1'b0} : cur) >= (diff ? {last[1], 1'b0} : last))
            next_ch = 2'd0;
        else
            next_ch = cur + step;
    endfunction

    // One-hot input select from channel number
    function automatic logic [3:0] onehot(input logic [1:0] ch);
        onehot = 4'h1 << ch;
    endfunction

    wire logic [1:0] pos_ch = conv_ch_q;
    wire logic [1:0] neg_ch = {conv_ch_q[1], ~conv_ch_q[0]};
    assign vin_pos_sel = onehot(pos_ch);
    assign vin_neg_sel = diff_mode ? onehot(neg_ch) : 4'h0;
    assign neg_to_analog_ground = !diff_mode;

    // Channel for the next conversion
    wire logic [1:0] take_ch = seq_on ? ptr_q : addr;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `ACS_CTRL_RST;
            ack_q <= 1'b0;
        end else begin
            ack_q <= wb_req;
            if (ctrl_wr) ctrl_q <= ctrl_new;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            // Idle levels of both pins, so reset makes no false edge
            strobe_q <= 1'b1;
            clk_q <= 1'b1;
        end else begin
            strobe_q <= convert_start_strobe;
            clk_q <= conversion_clock;
        end
    end

    // Sequence pointer
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_q <= 2'd0;
        end else if (ctrl_wr && new_seq_on) begin
            ptr_q <= 2'd0;
        end else if (seq_on && strobe_fall) begin
            ptr_q <= next_ch(ptr_q, addr, diff_mode);
        end
    end

    // Conversion timing: count falling conversion clock edges
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ACS_IDLE;
            tick_cnt_q <= 4'd0;
            conv_ch_q <= 2'd0;
            aborted_q <= 1'b0;
        end else begin
            case (st_q)
                ACS_IDLE: begin
                    if (strobe_fall && !asleep_q) begin
                        st_q <= ACS_CONV;
                        tick_cnt_q <= 4'd0;
                        conv_ch_q <= take_ch;
                        aborted_q <= 1'b0;
                    end
                end
                ACS_CONV: begin
                    if (strobe_rise &&
                        tick_cnt_q < 4'(`ACS_CONV_PERIODS)) begin
                        st_q <= ACS_IDLE;
                        aborted_q <= 1'b1;
                    end else if (tick) begin
                        tick_cnt_q <= tick_cnt_q + 4'd1;
                        if (tick_cnt_q == 4'(`ACS_CONV_PERIODS - 1))
                            st_q <= ACS_DONE;
                    end
                end
                ACS_DONE: st_q <= ACS_IDLE;
                default: st_q <= ACS_IDLE;
            endcase
        end
    end

    wire logic sar_start = (st_q == ACS_IDLE) && strobe_fall && !asleep_q;
    wire logic sar_tick = (st_q == ACS_CONV) && tick &&
        tick_cnt_q >= 4'(`ACS_CONV_PERIODS - RES_BITS);
    assign sif.start = sar_start;
    assign sif.tick = sar_tick;
    assign sif.abort = (st_q == ACS_CONV) && strobe_rise &&
        tick_cnt_q < 4'(`ACS_CONV_PERIODS);

    // Output coding: invert MSB for twos complement
    wire logic [11:0] msb_mask = 12'(1 << (RES_BITS - 1));
    wire logic [11:0] coded = ctrl_q[`ACS_F_CODING] ?
        (sif.code ^ msb_mask) : sif.code;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            result_q <= 12'h000;
            valid_q <= 1'b0;
        end else if (st_q == ACS_DONE && sif.done) begin
            result_q <= coded;
            valid_q <= 1'b1;
        end else if (sif.abort) begin
            valid_q <= 1'b0;
        end
    end
    assign result_valid = valid_q;

    // Power: auto modes sleep after each conversion until the next strobe rise
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            asleep_q <= 1'b0;
        end else if (pm == ACS_PM_FULL_SHUT) begin
            asleep_q <= 1'b1;
        end else if (pm == ACS_PM_NORMAL || strobe_rise) begin
            asleep_q <= 1'b0;
        end else if (st_q == ACS_DONE) begin
            asleep_q <= 1'b1;
        end
    end
    assign core_powered = !asleep_q;
    assign ref_powered = !asleep_q || (pm == ACS_PM_AUTO_STBY);

    wire logic [31:0] rd_mux =
        (wb_adr_i == `ACS_OFS_CTRL) ? {20'h00000, ctrl_q} :
        (wb_adr_i == `ACS_OFS_STAT) ? {24'h000000, aborted_q, valid_q,
            asleep_q, (st_q == ACS_CONV), 2'b00, ptr_q} :
        (wb_adr_i == `ACS_OFS_RSLT) ? {20'h00000, result_q} : 32'h00000000;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) wb_dat_o <= 32'h00000000;
        else if (wb_req && !wb_we_i) wb_dat_o <= rd_mux;
    end
    assign wb_ack_o = ack_q;

    property p_done_after_13;
        @(posedge ref_clk) disable iff (!rst_n)
        (st_q == ACS_DONE) |->
        $past(tick_cnt_q) == 4'(`ACS_CONV_PERIODS - 1);
    endproperty
    a_done_after_13: assert property (p_done_after_13)
        else $error("conversion ended early");
    property p_abort_invalid;
        @(posedge ref_clk) disable iff (!rst_n)
        sif.abort |=> !valid_q;
    endproperty
    a_abort_invalid: assert property (p_abort_invalid)
        else $error("abort left result valid");
    property p_seq_restart;
        @(posedge ref_clk) disable iff (!rst_n)
        (ctrl_wr && new_seq_on) |=> ptr_q == 2'd0;
    endproperty
    a_seq_restart: assert property (p_seq_restart)
        else $error("sequence did not restart");
    property p_se_ground;
        @(posedge ref_clk) disable iff (!rst_n)
        (!diff_mode) |-> neg_to_analog_ground && vin_neg_sel == 4'h0;
    endproperty
    a_se_ground: assert property (p_se_ground)
        else $error("single-ended negative not grounded");
    property p_pair;
        @(posedge ref_clk) disable iff (!rst_n)
        diff_mode |-> (vin_neg_sel == onehot(pos_ch ^ 2'd1));
    endproperty
    a_pair: assert property (p_pair)
        else $error("bad differential pair");
    property p_seq_lower;
        @(posedge ref_clk) disable iff (!rst_n)
        (seq_on && diff_mode && strobe_fall && !(ctrl_wr && new_seq_on))
        |=> ptr_q[0] == 1'b0;
    endproperty
    a_seq_lower: assert property (p_seq_lower)
        else $error("inverse pair sequenced");
    property p_seq_adv;
        @(posedge ref_clk) disable iff (!rst_n)
        (seq_on && !diff_mode && strobe_fall && ptr_q < addr && !ctrl_wr)
        |=> ptr_q == $past(ptr_q) + 2'd1;
    endproperty
    a_seq_adv: assert property (p_seq_adv)
        else $error("sequencer did not advance");
    property p_manual_ch;
        @(posedge ref_clk) disable iff (!rst_n)
        (sar_start && !seq_on) |=> conv_ch_q == $past(addr);
    endproperty
    a_manual_ch: assert property (p_manual_ch)
        else $error("wrong manual channel");
    property p_coding;
        @(posedge ref_clk) disable iff (!rst_n)
        (st_q == ACS_DONE && sif.done) |=>
        result_q == ($past(ctrl_q[`ACS_F_CODING]) ?
            ($past(sif.code) ^ msb_mask) : $past(sif.code));
    endproperty
    a_coding: assert property (p_coding)
        else $error("bad output coding");
    property p_shutdown;
        @(posedge ref_clk) disable iff (!rst_n)
        (pm == ACS_PM_FULL_SHUT) |=> !core_powered;
    endproperty
    a_shutdown: assert property (p_shutdown)
        else $error("shutdown left core powered");
    property p_seq_wrap;
        @(posedge ref_clk) disable iff (!rst_n)
        (seq_on && !diff_mode && strobe_fall && ptr_q == addr && !ctrl_wr)
        |=> ptr_q == 2'd0;
    endproperty
    a_seq_wrap: assert property (p_seq_wrap)
        else $error("sequence did not wrap to channel 0");
    property p_pseudo;
        @(posedge ref_clk) disable iff (!rst_n)
        (ctrl_q[`ACS_F_TYP_B0] && !ctrl_q[`ACS_F_TYP_B1]) |->
        !neg_to_analog_ground && vin_neg_sel == onehot(pos_ch ^ 2'd1);
    endproperty
    a_pseudo: assert property (p_pseudo)
        else $error("bad pseudo differential pair");
    property p_sleep_refuse;
        @(posedge ref_clk) disable iff (!rst_n)
        (st_q == ACS_IDLE && strobe_fall && asleep_q) |=> st_q == ACS_IDLE;
    endproperty
    a_sleep_refuse: assert property (p_sleep_refuse)
        else $error("conversion started while powered down");
    property p_ctrl_kept;
        @(posedge ref_clk) disable iff (!rst_n)
        (pm == ACS_PM_FULL_SHUT && !ctrl_wr) |=> $stable(ctrl_q);
    endproperty
    a_ctrl_kept: assert property (p_ctrl_kept)
        else $error("control word lost in shutdown");
    c_sleep_wake: cover property (@(posedge ref_clk) asleep_q && strobe_rise);
    c_diff_seq: cover property (@(posedge ref_clk)
        seq_on && diff_mode && strobe_fall);
    c_conv_done: cover property (@(posedge ref_clk) st_q == ACS_DONE);
    c_abort: cover property (@(posedge ref_clk) sif.abort);
    c_wrap: cover property (@(posedge ref_clk)
        seq_on && strobe_fall && ptr_q == addr);
endmodule // acs_ctrl

// [acs_host_model.sv]
// Purpose: Host side model for strobe, conversion clock and comparator
// Assumes: Conversion clock idles high, four ref_clk cycles a period
// Notes: Clock stands still between frames
`timescale 1ns/10ps
module acs_host_model (
    input wire logic ref_clk,
    output logic convert_start_strobe,
    output logic conversion_clock,
    output logic comp_hi
);
    initial begin
        convert_start_strobe = 1'b1;
        conversion_clock = 1'b1;
        comp_hi = 1'b0;
    end

    // Short count aborts at the closing rise; the next start clears abort state
    task automatic convert(input int n, input logic b);
        @(posedge ref_clk);
        comp_hi <= b;
        convert_start_strobe <= 1'b0;
        repeat (2) @(posedge ref_clk);
        for (int i = 0; i < n; i++) begin
            repeat (2) @(posedge ref_clk);
            conversion_clock <= 1'b0;
            repeat (2) @(posedge ref_clk);
            conversion_clock <= 1'b1;
        end
        repeat (2) @(posedge ref_clk);
        convert_start_strobe <= 1'b1;
    endtask

    // Short strobe: wakes a sleeping core, else latches channel and aborts
    task automatic pulse();
        @(posedge ref_clk);
        convert_start_strobe <= 1'b0;
        repeat (2) @(posedge ref_clk);
        convert_start_strobe <= 1'b1;
        repeat (4) @(posedge ref_clk);
    endtask
endmodule // acs_host_model

// [adc_channel_sequencer_control_tb.sv]
// Purpose: Self-checking bench for the converter control block
// Assumes: One-cycle Wishbone ack, result at 0x08, status at 0x04
// Notes: Partner model drives strobe, conversion clock, comparator
`timescale 1ns/10ps
module adc_channel_sequencer_control_tb;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_o, q;
    logic wb_ack_o, strobe, cclk, comp_hi, gnd, ref_on, core_on, valid;
    logic [3:0] pos, neg;
    int fails = 0;
    int check_count = 0;

    always #12.5 ref_clk = ~ref_clk;

    acs_host_model hm (.ref_clk(ref_clk), .convert_start_strobe(strobe),
        .conversion_clock(cclk), .comp_hi(comp_hi));

    acs_ctrl #(.RES_BITS(12), .CLK_DIV(4)) DUT (.ref_clk(ref_clk),
        .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .convert_start_strobe(strobe), .conversion_clock(cclk),
        .comp_hi(comp_hi), .vin_pos_sel(pos), .vin_neg_sel(neg),
        .neg_to_analog_ground(gnd), .ref_powered(ref_on),
        .core_powered(core_on), .result_valid(valid));

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        q = wb_dat_o;
        if (n >= 50) begin
            fails++;
            end_of_test();
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge ref_clk);
    endtask

    function automatic logic [31:0] cw(input logic [1:0] pm,
        input logic cod, input logic [1:0] add, input logic [1:0] md,
        input logic [1:0] sq);
        return {20'h0, pm, cod, 2'b00, add, md, sq, 1'b0};
    endfunction

    // Full frame, then bounded wait for the result flag
    task automatic conv_ok(input logic b);
        int n;
        hm.convert(13, b);
        n = 0;
        while (valid !== 1'b1 && n < 40) begin
            @(posedge ref_clk);
            n++;
        end
        check(32'(valid), 32'h1);
    endtask

    task automatic t_reset();
        check({gnd, ref_on, core_on, valid, pos, neg}, 32'h0E10);
        wb(1'b0, 8'h00, 32'h0);
        check(q, 32'h0);
        wb(1'b0, 8'hFC, 32'h0);
        check(q, 32'h0);
    endtask

    task automatic t_decode();
        logic [1:0] mds [3] = '{2'b00, 2'b10, 2'b01};
        logic [3:0] en;
        // Input type 11 is never written
        foreach (mds[m]) begin
            for (int a = 0; a < 4; a++) begin
                wb(1'b1, 8'h00, cw(2'b00, 1'b0, 2'(a), mds[m], 2'b00));
                // Selects follow the channel latched at a start
                hm.pulse();
                en = (mds[m] == 2'b00) ? 4'h0 : 4'h1 << (a ^ 1);
                check({pos, neg, 3'b000, gnd},
                    {4'h1 << a, en, 3'b000, mds[m] == 2'b00});
            end
        end
    endtask

    task automatic t_code();
        logic [11:0] ex [4] = '{12'h000, 12'h800, 12'hFFF, 12'h7FF};
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, 8'h00, cw(2'b00, i[0], 2'b00, 2'b00, 2'b00));
            conv_ok(i[1]);
            wb(1'b0, 8'h08, 32'h0);
            check(q, 32'(ex[i]));
        end
    endtask

    task automatic t_abort();
        hm.convert(12, 1'b1);
        repeat (4) @(posedge ref_clk);
        check(32'(valid), 32'h0);
        wb(1'b0, 8'h04, 32'h0);
        check(32'(q[7:6]), 32'h2);
    endtask

    // Mixed sequence codes are never written
    task automatic t_seq(input logic [1:0] md, input logic [1:0] a,
        input logic [15:0] ex);
        wb(1'b1, 8'h00, cw(2'b00, 1'b0, a, md, 2'b11));
        for (int i = 0; i < 4; i++) begin
            fork
                hm.convert(13, 1'b1);
                begin
                    repeat (12) @(posedge ref_clk);
                    check(32'(pos), 32'(ex[4*i +: 4]));
                end
            join
            repeat (6) @(posedge ref_clk);
        end
    endtask

    // Sleep shows between result and closing rise, which wakes the core
    task automatic t_auto(input logic [1:0] pm, input logic b,
        input logic [31:0] pw);
        wb(1'b1, 8'h00, cw(pm, 1'b0, 2'b00, 2'b00, 2'b00));
        hm.pulse();
        fork
            conv_ok(b);
            begin
                repeat (56) @(posedge ref_clk);
                check({ref_on, core_on}, pw);
            end
        join
        wb(1'b0, 8'h08, 32'h0);
        check(q, b ? 32'hFFF : 32'h000);
    endtask

    task automatic t_power();
        wb(1'b1, 8'h00, cw(2'b11, 1'b1, 2'b01, 2'b00, 2'b00));
        repeat (2) @(posedge ref_clk);
        check({ref_on, core_on}, 32'h0);
        wb(1'b0, 8'h00, 32'h0);
        check(q, cw(2'b11, 1'b1, 2'b01, 2'b00, 2'b00));
        t_auto(2'b10, 1'b0, 32'h2);
        t_auto(2'b01, 1'b1, 32'h0);
    endtask

    initial begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_decode();
        t_code();
        t_abort();
        t_seq(2'b00, 2'b10, 16'h1421);
        t_seq(2'b10, 2'b11, 16'h4141);
        t_power();
        end_of_test();
    end
endmodule // adc_channel_sequencer_control_tb
